/* cag_pkg.sv */
package cag_pkg;

  // ==========================================================
  // Widths
  localparam int CAG_AW = 16;
  localparam int CAG_DW = 8;

  // ==========================================================
  // Fixed address regions
  localparam logic [15:0] CAG_SHORT_CALL_BASE = 16'h0800;
  localparam logic [15:0] CAG_VECTOR_BASE = 16'h0040;
  localparam logic [15:0] CAG_VECTOR_LAST = 16'h007F;
  localparam logic [15:0] CAG_SADDR_LO = 16'hFE20;
  localparam logic [15:0] CAG_SADDR_HI = 16'hFF1F;
  localparam logic [15:0] CAG_SADDR_RAM_LAST = 16'hFEFF;
  localparam logic [15:0] CAG_SFR_BASE = 16'hFF00;
  localparam logic [15:0] CAG_SFR_GAP_LO = 16'hFFD0;
  localparam logic [15:0] CAG_SFR_GAP_HI = 16'hFFDF;
  localparam logic [7:0] CAG_SADDR_WRAP = 8'h20;
  localparam logic [6:0] CAG_SADDR_TOP = 7'h7F;
  localparam logic [15:0] CAG_PC_RESET = 16'h0000;
  localparam logic [2:0] CAG_REG_A = 3'h1;
  localparam logic [1:0] CAG_PAIR_AX = 2'h0;

  // ==========================================================
  // Branch target kinds
  typedef enum logic [2:0] {
    CAG_BR_NONE = 3'b000,
    CAG_BR_REL = 3'b001,
    CAG_BR_IMM16 = 3'b010,
    CAG_BR_SHORT_CALL = 3'b011,
    CAG_BR_TABLE = 3'b100,
    CAG_BR_PAIR = 3'b101
  } cag_branch_t;

  // Operand address kinds
  typedef enum logic [2:0] {
    CAG_OP_NONE = 3'b000,
    CAG_OP_IMPLIED = 3'b001,
    CAG_OP_REG = 3'b010,
    CAG_OP_DIRECT = 3'b011,
    CAG_OP_SHORT = 3'b100,
    CAG_OP_SFR = 3'b101
  } cag_operand_t;

  // Implied operand instructions
  typedef enum logic [2:0] {
    CAG_IMP_MULTIPLY = 3'b000,
    CAG_IMP_DIVIDE = 3'b001,
    CAG_IMP_ADJ_ADD = 3'b010,
    CAG_IMP_ADJ_SUB = 3'b011,
    CAG_IMP_ROT_RIGHT = 3'b100,
    CAG_IMP_ROT_LEFT = 3'b101
  } cag_implied_t;

endpackage

/* cag_short_direct.sv */
`timescale 1ns/1ps
// ==========================================================
// Short direct address former, combinational
module cag_short_direct
  import cag_pkg::*;
(
  input wire logic [7:0] field,
  output logic [15:0] addr,
  output logic is_sfr
);
  // Bit 8 set only for the wrapped low fields
  always_comb begin
    addr = {CAG_SADDR_TOP, (field < CAG_SADDR_WRAP), field};
    is_sfr = (field < CAG_SADDR_WRAP);
  end
endmodule

/* cag_address_gen.sv */
`timescale 1ns/1ps
// Operation
// - PC advances by instruction byte count unless a branch loads a target.
// - Displacement sign-extended from bit 7, added to next instruction address.
// - Short branch and all conditional branches use relative targets.
// - Long call and long branch load a full 16-bit immediate.
// - Short-form call targets stay in 0800H to 0FFFH.
// - Table call reads vector entry selected by opcode bits 1 to 5.
// - Register branch copies accumulator pair into the PC.
// - Byte multiply uses accumulator factor and accumulator pair product.
// - Word divide reads and writes the accumulator pair.
// - Decimal adjust and nibble rotates use the 8-bit accumulator.
// - Register operand picks bank flags plus 3-bit opcode code.
// - Numbered and functional register names map to same hardware.
// - Direct addressing uses 16-bit immediate reaching all memory.
// - Short direct reaches 256-byte window FE20H to FF1FH.
// - Short direct bit 8 is 1 only for fields 00H to 1FH.
// - FE20H to FEFFH is RAM, FF00H to FF1FH is special registers.
// - Word short direct operands use even addresses only.
// - Special register addressing uses byte as low address, skipping FFD0H-FFDFH.
module cag_address_gen
  import cag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // Fetch and decode side
  input wire logic insn_valid,
  input wire logic [2:0] insn_length,
  input wire cag_branch_t branch_kind,
  input wire logic branch_taken,
  input wire logic [7:0] relative_displacement,
  input wire logic [15:0] full_immediate_address,
  input wire logic [10:0] short_call_target,
  input wire logic [7:0] opcode,
  input wire logic [15:0] vector_entry,
  input wire logic [15:0] accumulator_pair,
  input wire cag_operand_t operand_kind,
  input wire cag_implied_t implied_kind,
  input wire logic [2:0] reg_code,
  input wire logic reg_is_pair,
  input wire logic [7:0] operand_field,
  input wire logic operand_is_word,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  // Results
  output logic [15:0] pc_q,
  output logic [15:0] vector_addr_q,
  output logic vector_valid_q,
  output logic [15:0] operand_addr_q,
  output logic operand_valid_q,
  output logic operand_is_reg_q,
  output logic [4:0] reg_index_q,
  output logic [4:0] reg_dest_q,
  output logic operand_in_sfr_q,
  output logic operand_in_ram_q,
  output logic operand_error_q
);

  // ==========================================================
  // Elaboration checks
  // The address formers below hard-wire the window shapes into
  // concatenations, so constants that no longer fit them are refused
  // here instead of quietly producing wrong addresses.
  if (CAG_AW != 16) begin : g_chk_aw
    $error("address generator serves 16-bit addresses only");
  end
  if (CAG_DW != 8) begin : g_chk_dw
    $error("address generator serves 8-bit data only");
  end
  // Short direct window: FE20H up, wrapped tail ends at FF1FH
  if (CAG_SADDR_LO != {CAG_SADDR_TOP, 1'b0, CAG_SADDR_WRAP}) begin : g_chk_saddr_lo
    $error("short direct window start does not match the former");
  end
  if (CAG_SADDR_HI != {CAG_SADDR_TOP, 1'b1, CAG_SADDR_WRAP - 8'h01}) begin : g_chk_saddr_hi
    $error("short direct window end does not match the former");
  end
  // RAM part ends where the bit 8 split puts it
  if (CAG_SADDR_RAM_LAST != {CAG_SADDR_TOP, 1'b0, 8'hFF}) begin : g_chk_ram_last
    $error("short direct RAM end does not match the former");
  end
  if (CAG_SFR_BASE != {CAG_SADDR_TOP, 1'b1, 8'h00}) begin : g_chk_sfr_base
    $error("register space must start where bit 8 is set");
  end
  // Register addressing only supplies the low byte
  if (CAG_SFR_GAP_LO[15:8] != CAG_SFR_BASE[15:8]) begin : g_chk_gap_lo
    $error("register hole must share the fixed high byte");
  end
  if (CAG_SFR_GAP_HI[15:8] != CAG_SFR_BASE[15:8]) begin : g_chk_gap_hi
    $error("register hole must share the fixed high byte");
  end
  // Vector index is ORed in, so the base must be aligned to the table
  if (CAG_VECTOR_BASE[5:0] != 6'h00) begin : g_chk_vec_base
    $error("vector table base must be 64-byte aligned");
  end
  if (CAG_VECTOR_LAST != (CAG_VECTOR_BASE | 16'h003F)) begin : g_chk_vec_last
    $error("vector table must hold 32 two-byte entries");
  end
  // Short call immediate is ORed below the region bit
  if (CAG_SHORT_CALL_BASE[10:0] != 11'h000) begin : g_chk_call_base
    $error("short call region base must leave bits 10 to 0 clear");
  end

  // ==========================================================
  // Next PC computation
  logic [15:0] next_insn;
  logic [15:0] disp_ext;
  logic [15:0] pc_d;
  logic [15:0] short_addr;
  logic short_sfr;
  logic [1:0] bank;

  assign bank = {bank_select_high, bank_select_low};

  assign next_insn = pc_q + {13'h0000, insn_length};
  assign disp_ext = {{8{relative_displacement[7]}}, relative_displacement};

  // Target select; no branch or an untaken one simply falls through.
  // The relative base is the advanced PC, i.e. the next instruction,
  // never the address of the branch itself.
  always_comb begin
    pc_d = next_insn;
    if (branch_taken) begin
      case (branch_kind)
        // relative branches; 16-bit sum drops carry
        CAG_BR_REL: pc_d = next_insn + disp_ext;
        CAG_BR_IMM16: pc_d = full_immediate_address;
        // bit 11 set, upper cleared
        // Bit 11 comes from the base, so no immediate can leave the region
        CAG_BR_SHORT_CALL: pc_d = CAG_SHORT_CALL_BASE | {5'h00, short_call_target};
        CAG_BR_TABLE: pc_d = vector_entry;
        CAG_BR_PAIR: pc_d = accumulator_pair;
        default: pc_d = next_insn;
      endcase
    end
  end

  // Program counter register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= CAG_PC_RESET;
    end else if (insn_valid) begin
      pc_q <= pc_d;
    end
  end

  // ==========================================================
  // Vector table lookup address
  // index from opcode bits 1 to 5, even entries inside 0040H-007FH
  // Held between table calls so fetch may read the entry at leisure
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vector_addr_q <= CAG_VECTOR_BASE;
    end else if (insn_valid && (branch_kind == CAG_BR_TABLE)) begin
      vector_addr_q <= CAG_VECTOR_BASE | {10'h000, opcode[5:1], 1'b0};
    end
  end

  // Table call strobe, one cycle per accepted table call
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vector_valid_q <= 1'b0;
    end else begin
      vector_valid_q <= insn_valid && (branch_kind == CAG_BR_TABLE);
    end
  end

  // ==========================================================
  // Short direct address former
  cag_short_direct u_short (
    .field(operand_field),
    .addr(short_addr),
    .is_sfr(short_sfr)
  );

  // ==========================================================
  // Register file indices, bank flags on top
  // A pair is addressed through its even byte register, so the numbered
  // and functional names of one register always meet on one index.
  logic [4:0] idx_acc;
  logic [4:0] idx_pair_acc;
  logic [4:0] idx_byte;
  logic [4:0] idx_pair;

  // bank flags over the opcode code
  assign idx_acc = {bank, CAG_REG_A};
  assign idx_pair_acc = {bank, CAG_PAIR_AX, 1'b0};
  assign idx_byte = {bank, reg_code};
  assign idx_pair = {bank, reg_code[1:0], 1'b0};

  // ==========================================================
  // Operand effective address
  logic [15:0] op_addr_d;
  logic op_reg_d;
  logic [4:0] reg_idx_d;
  logic [4:0] reg_dst_d;
  logic sfr_d;
  logic ram_d;
  logic err_d;

  always_comb begin
    op_addr_d = 16'h0000;
    op_reg_d = 1'b0;
    reg_idx_d = 5'h00;
    reg_dst_d = 5'h00;
    sfr_d = 1'b0;
    ram_d = 1'b0;
    err_d = 1'b0;
    case (operand_kind)
      CAG_OP_IMPLIED: begin
        op_reg_d = 1'b1;
        case (implied_kind)
          // factor A, product into the pair
          CAG_IMP_MULTIPLY: begin
            reg_idx_d = idx_acc;
            reg_dst_d = idx_pair_acc;
          end
          CAG_IMP_DIVIDE: begin
            reg_idx_d = idx_pair_acc;
            reg_dst_d = idx_pair_acc;
          end
          // accumulator only
          // Both adjusts and both nibble rotates land here
          default: begin
            reg_idx_d = idx_acc;
            reg_dst_d = idx_acc;
          end
        endcase
      end
      CAG_OP_REG: begin
        // bank plus code; one index per register whatever its name
        op_reg_d = 1'b1;
        if (reg_is_pair) begin
          reg_idx_d = idx_pair;
        end else begin
          reg_idx_d = idx_byte;
        end
        reg_dst_d = reg_idx_d;
      end
      CAG_OP_DIRECT: begin
        op_addr_d = full_immediate_address;
        // Only the register page is marked; RAM is not decoded here
        sfr_d = (full_immediate_address >= CAG_SFR_BASE);
      end
      CAG_OP_SHORT: begin
        op_addr_d = short_addr;
        sfr_d = short_sfr;
        ram_d = !short_sfr;
        err_d = operand_is_word && operand_field[0];
      end
      CAG_OP_SFR: begin
        // high byte fixed, hole FFD0H-FFDFH flagged as error
        // The hole is only flagged; the access itself is left to the bus
        op_addr_d = CAG_SFR_BASE | {8'h00, operand_field};
        sfr_d = 1'b1;
        err_d = (op_addr_d >= CAG_SFR_GAP_LO) && (op_addr_d <= CAG_SFR_GAP_HI);
      end
      default: begin
        op_addr_d = 16'h0000;
      end
    endcase
  end

  // Operand strobe, one cycle per fetched instruction with an operand
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operand_valid_q <= 1'b0;
    end else begin
      operand_valid_q <= insn_valid && (operand_kind != CAG_OP_NONE);
    end
  end

  // Operand result registers; they stand until the next instruction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operand_addr_q <= 16'h0000;
      operand_is_reg_q <= 1'b0;
      reg_index_q <= 5'h00;
      reg_dest_q <= 5'h00;
      operand_in_sfr_q <= 1'b0;
      operand_in_ram_q <= 1'b0;
      operand_error_q <= 1'b0;
    end else if (insn_valid) begin
      operand_addr_q <= op_addr_d;
      operand_is_reg_q <= op_reg_d;
      reg_index_q <= reg_idx_d;
      reg_dest_q <= reg_dst_d;
      operand_in_sfr_q <= sfr_d;
      operand_in_ram_q <= ram_d;
      operand_error_q <= err_d;
    end
  end

endmodule

/* cag_address_gen_chk.sv */
`timescale 1ns/1ps
// ==========================================================
// Port-level checker for the address generator
module cag_address_gen_chk
  import cag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic insn_valid,
  input wire logic [2:0] insn_length,
  input wire cag_branch_t branch_kind,
  input wire logic branch_taken,
  input wire logic [7:0] relative_displacement,
  input wire logic [15:0] full_immediate_address,
  input wire logic [10:0] short_call_target,
  input wire logic [7:0] opcode,
  input wire logic [15:0] vector_entry,
  input wire logic [15:0] accumulator_pair,
  input wire cag_operand_t operand_kind,
  input wire logic [7:0] operand_field,
  input wire logic operand_is_word,
  input wire logic [15:0] pc_q,
  input wire logic [15:0] vector_addr_q,
  input wire logic vector_valid_q,
  input wire logic [15:0] operand_addr_q,
  input wire logic operand_in_sfr_q,
  input wire logic operand_in_ram_q,
  input wire logic operand_error_q
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Branch targets, all judged one cycle after the accepting edge
  AST_FALL: assert property (
    insn_valid && !branch_taken |=> pc_q == $past(pc_q) + 16'($past(insn_length)))
    else $error("pc fall-through wrong");
  AST_REL: assert property (
    insn_valid && branch_taken && branch_kind == CAG_BR_REL |=> pc_q == $past(pc_q)
    + 16'($past(insn_length)) + {{8{$past(relative_displacement[7])}},
    $past(relative_displacement)}) else $error("relative target wrong");
  AST_IMM: assert property (
    insn_valid && branch_taken && branch_kind == CAG_BR_IMM16
    |=> pc_q == $past(full_immediate_address)) else $error("long target wrong");
  AST_SCALL: assert property (
    insn_valid && branch_taken && branch_kind == CAG_BR_SHORT_CALL
    |=> pc_q == {5'h01, $past(short_call_target)}) else $error("short call wrong");
  AST_TABLE: assert property (
    insn_valid && branch_taken && branch_kind == CAG_BR_TABLE |=> vector_valid_q
    && pc_q == $past(vector_entry) && vector_addr_q == {10'h001, $past(opcode[5:1]), 1'b0})
    else $error("table call wrong");
  AST_PAIR: assert property (
    insn_valid && branch_taken && branch_kind == CAG_BR_PAIR
    |=> pc_q == $past(accumulator_pair)) else $error("pair branch wrong");

  // ==========================================================
  // Operand addresses
  AST_DIRECT: assert property (
    insn_valid && operand_kind == CAG_OP_DIRECT
    |=> operand_addr_q == $past(full_immediate_address)) else $error("direct wrong");
  AST_SHORT: assert property (
    insn_valid && operand_kind == CAG_OP_SHORT |=> operand_addr_q
    == {7'h7F, $past(operand_field) < 8'h20, $past(operand_field)})
    else $error("short address wrong");
  AST_REGION: assert property (
    insn_valid && operand_kind == CAG_OP_SHORT |=> operand_in_sfr_q
    == ($past(operand_field) < 8'h20) && operand_in_ram_q != operand_in_sfr_q)
    else $error("short region wrong");
  AST_ODD: assert property (
    insn_valid && operand_kind == CAG_OP_SHORT && operand_is_word
    |=> operand_error_q == $past(operand_field[0])) else $error("odd word missed");
  AST_SFR: assert property (
    insn_valid && operand_kind == CAG_OP_SFR |=> operand_addr_q
    == {8'hFF, $past(operand_field)} && operand_error_q == ($past(operand_field[7:4]) == 4'hD))
    else $error("sfr address wrong");
endmodule

bind cag_address_gen cag_address_gen_chk u_chk (.*);

/* tb_cag_address_gen.sv */
`timescale 1ns/1ps
module tb_cag_address_gen;
  import cag_pkg::*;
  logic clk, rst_n, insn_valid, branch_taken, reg_is_pair, operand_is_word;
  logic bank_select_low, bank_select_high, vector_valid_q, operand_valid_q;
  logic operand_is_reg_q, operand_in_sfr_q, operand_in_ram_q, operand_error_q;
  logic [2:0] insn_length, reg_code;
  logic [4:0] reg_index_q, reg_dest_q;
  logic [7:0] relative_displacement, opcode, operand_field;
  logic [10:0] short_call_target;
  logic [15:0] full_immediate_address, vector_entry, accumulator_pair;
  logic [15:0] pc_q, vector_addr_q, operand_addr_q, epc;
  cag_branch_t branch_kind;
  cag_operand_t operand_kind;
  cag_implied_t implied_kind;
  int errors, compares;

  cag_address_gen dut (.*);

  // ==========================================================
  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Shared helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Called at an edge; one request, outputs settled on return
  task go(input cag_branch_t bk, input logic tk, input logic [2:0] len, input cag_operand_t ok);
    insn_valid <= 1'b1;
    branch_kind <= bk;
    branch_taken <= tk;
    insn_length <= len;
    operand_kind <= ok;
    @(posedge clk);
    insn_valid <= 1'b0;
    #1;
    epc = epc + 16'(len);
  endtask

  task finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task t_rel;
    logic [7:0] d[4] = '{8'h7F, 8'h80, 8'hFE, 8'h00};
    @(posedge clk);
    full_immediate_address <= 16'hFFF0;
    go(CAG_BR_IMM16, 1'b1, 3'h3, CAG_OP_NONE);
    epc = 16'hFFF0;
    chk(pc_q, epc);
    // Both extremes of reach, crossing the top of memory
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      relative_displacement <= d[i];
      go(CAG_BR_REL, 1'b1, 3'h2, CAG_OP_NONE);
      epc = epc + {{8{d[i][7]}}, d[i]};
      chk(pc_q, epc);
    end
    for (int n = 1; n < 5; n++) begin
      @(posedge clk);
      go(CAG_BR_REL, 1'b0, 3'(n), CAG_OP_NONE);
      chk(pc_q, epc);
    end
    $display("t_rel done");
  endtask

  task t_tgt;
    @(posedge clk);
    short_call_target <= 11'h7FF;
    go(CAG_BR_SHORT_CALL, 1'b1, 3'h2, CAG_OP_NONE);
    chk(pc_q, 16'h0FFF);
    @(posedge clk);
    short_call_target <= 11'h000;
    go(CAG_BR_SHORT_CALL, 1'b1, 3'h2, CAG_OP_NONE);
    chk(pc_q, 16'h0800);
    @(posedge clk);
    opcode <= 8'h3E;
    vector_entry <= 16'hBEEF;
    go(CAG_BR_TABLE, 1'b1, 3'h1, CAG_OP_NONE);
    chk(pc_q, 16'hBEEF);
    chk(vector_addr_q, 16'h007E);
    chk(16'(vector_valid_q), 16'h0001);
    @(posedge clk);
    accumulator_pair <= 16'h1234;
    go(CAG_BR_PAIR, 1'b1, 3'h2, CAG_OP_NONE);
    chk(pc_q, 16'h1234);
    $display("t_tgt done");
  endtask

  task t_opnd;
    logic [7:0] f[6] = '{8'h00, 8'h1F, 8'h20, 8'hFF, 8'h21, 8'h30};
    logic [7:0] s[3] = '{8'hCF, 8'hD5, 8'hE0};
    // Window edges, then odd and even word addresses
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      operand_field <= f[i];
      operand_is_word <= (i > 3);
      go(CAG_BR_NONE, 1'b0, 3'h2, CAG_OP_SHORT);
      chk(operand_addr_q, {7'h7F, f[i] < 8'h20, f[i]});
      chk(16'(operand_in_sfr_q), 16'(f[i] < 8'h20));
      chk(16'(operand_in_ram_q), 16'(f[i] >= 8'h20));
      chk(16'(operand_error_q), 16'(i > 3 && f[i][0]));
    end
    @(posedge clk);
    full_immediate_address <= 16'hFE00;
    go(CAG_BR_NONE, 1'b0, 3'h3, CAG_OP_DIRECT);
    chk(operand_addr_q, 16'hFE00);
    // Both sides of the hole in the register space
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      operand_field <= s[i];
      go(CAG_BR_NONE, 1'b0, 3'h2, CAG_OP_SFR);
      chk(operand_addr_q, {8'hFF, s[i]});
      chk(16'(operand_error_q), 16'(s[i][7:4] == 4'hD));
    end
    $display("t_opnd done");
  endtask

  task t_reg;
    logic [15:0] a, p;
    logic [4:0] e;
    // Every implied form, bank flags walked along
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      {bank_select_high, bank_select_low} <= 2'(k);
      implied_kind <= cag_implied_t'(3'(k));
      go(CAG_BR_NONE, 1'b0, 3'h1, CAG_OP_IMPLIED);
      a = 16'({2'(k), CAG_REG_A});
      p = 16'({2'(k), CAG_PAIR_AX, 1'b0});
      chk(16'(reg_index_q), (k == 1) ? p : a);
      chk(16'(reg_dest_q), (k < 2) ? p : a);
      chk(16'(operand_is_reg_q), 16'h0001);
    end
    // Byte codes in banks 0 and 2, pair codes in banks 1 and 3; a pair shares its low byte's index
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {bank_select_high, bank_select_low} <= 2'(k);
      reg_is_pair <= k[0];
      reg_code <= 3'(7 - k);
      go(CAG_BR_NONE, 1'b0, 3'h1, CAG_OP_REG);
      e = k[0] ? {2'(k), 2'(7 - k), 1'b0} : {2'(k), 3'(7 - k)};
      chk(16'(reg_index_q), 16'(e));
      chk(16'(reg_dest_q), 16'(e));
      chk(16'(operand_valid_q), 16'h0001);
    end
    $display("t_reg done");
  endtask

  // ==========================================================
  // Watchdog at 4000 cycles, far beyond the fewer than 100 cycles needed
  initial begin
    #20000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // Main sequence
  initial begin
    {rst_n, insn_valid, branch_taken, reg_is_pair, operand_is_word} = '0;
    {bank_select_low, bank_select_high, insn_length, reg_code} = '0;
    {relative_displacement, opcode, operand_field, short_call_target} = '0;
    {full_immediate_address, vector_entry, accumulator_pair} = '0;
    branch_kind = CAG_BR_NONE;
    operand_kind = CAG_OP_NONE;
    implied_kind = CAG_IMP_MULTIPLY;
    epc = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pc_q, 16'h0000);
    chk(vector_addr_q, 16'h0040);
    @(posedge clk);
    t_rel();
    t_tgt();
    t_opnd();
    t_reg();
    finish_test();
  end
endmodule
